// File: pkg/tbi_pkg.sv
// package: register map, field positions, reset values and write masks
// assumes: five timer channels, 8-bit registers on a byte-addressed plain port
package tbi_pkg;

  // ==========================================================
  // geometry
  localparam int       NUM_CH   = 5;
  localparam int       AW       = 8;
  localparam int       DW       = 8;

  // ==========================================================
  // register offsets (one aligned word per register)
  localparam logic [7:0] MODE_BASE = 8'h00;  // timer_mode_control, ch n at +4n
  localparam logic [7:0] IE_BASE   = 8'h20;  // timer_interrupt_enable, ch n at +4n
  localparam logic [7:0] STAT_BASE = 8'h40;  // timer_status_reg, ch n at +4n
  localparam logic [7:0] IRQ_STAT  = 8'h60;
  localparam logic [7:0] IRQ_MASK  = 8'h64;

  // ==========================================================
  // field positions
  localparam int BIT_PAIR_EF   = 6;  // mode: pair_e_f_buffer_bit
  localparam int BIT_PAIR_BD   = 5;  // mode: pair_b_d_buffer_bit
  localparam int BIT_TROUGH_EN = 6;  // ie: trough_conv_start_enable
  localparam int BIT_UNDER_EN  = 5;  // ie / status: underflow
  localparam int BIT_OVER_EN   = 4;  // ie / status: overflow
  localparam int BIT_MATCH_D   = 3;  // ie / status: compare/capture d
  localparam int IRQ_W         = 4;
  localparam int EV_TROUGH     = 0;
  localparam int EV_OVER       = 1;
  localparam int EV_UNDER      = 2;
  localparam int EV_MATCH_D    = 3;

  // ==========================================================
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] IE_RST   = 8'h00;
  localparam logic [3:0] IRQ_RST  = 4'h0;

  // ==========================================================
  // writable bits per channel; everything else reads zero
  function automatic logic [7:0] tbi_mode_mask(input int ch);
    case (ch)
      0:       return 8'h7f;
      1, 2:    return 8'h1f;
      default: return 8'h3f;
    endcase
  endfunction : tbi_mode_mask

  function automatic logic [7:0] tbi_ie_mask(input int ch);
    case (ch)
      1, 2:    return 8'hb7;
      4:       return 8'hdf;
      default: return 8'h9f;
    endcase
  endfunction : tbi_ie_mask

  function automatic logic [7:0] tbi_reg_addr(input logic [7:0] base, input int ch);
    return base + 8'(ch * 4);
  endfunction : tbi_reg_addr

endpackage : tbi_pkg

// File: hdl/tbi_sticky.sv
// sticky flag bank: hardware sets, software clears by writing ones
// assumes: set and clear arrive synchronous to clk
`timescale 1ns/1ps
module tbi_sticky
  import tbi_pkg::*;
#(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // set and clear
  input  wire logic [W-1:0] set,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] clr_data,
  // state
  output logic      [W-1:0] q
);

  // ==========================================================
  // flags: a set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= (q & ~(clr_we ? clr_data : '0)) | set;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_set_wins: assert property ((set != '0) |=> ((q & $past(set)) == $past(set)))
    else $error("sticky set lost");

endmodule : tbi_sticky

// File: hdl/tbi_chan_regs.sv
// one channel's mode and interrupt-enable registers
// assumes: write strobes are already decoded for this channel
`timescale 1ns/1ps
module tbi_chan_regs
  import tbi_pkg::*;
#(
  parameter int CH = 0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // writes
  input  wire logic         mode_we,
  input  wire logic         ie_we,
  input  wire logic [DW-1:0] wdata,
  // register contents
  output logic      [DW-1:0] mode,
  output logic      [DW-1:0] ie
);

  // ==========================================================
  // mode register; reserved bits never store, so they read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= MODE_RST;
    end else if (mode_we) begin
      mode <= wdata & tbi_mode_mask(CH);
    end
  end

  // ==========================================================
  // interrupt enable register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ie <= IE_RST;
    end else if (ie_we) begin
      ie <= wdata & tbi_ie_mask(CH);
    end
  end

endmodule : tbi_chan_regs

// File: hdl/tbi_top.sv
// per-channel buffer pairing and interrupt enables of a five-channel timer
// assumes: counter logic supplies one-cycle event pulses and the mode decode
`timescale 1ns/1ps
module tbi_top
  import tbi_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // register port
  input  wire logic [AW-1:0]     addr,
  input  wire logic [DW-1:0]     wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DW-1:0]     rdata,
  // counter-side events and mode
  input  wire logic [NUM_CH-1:0] comp_pwm_mode,
  input  wire logic [NUM_CH-1:0] underflow_evt,
  input  wire logic [NUM_CH-1:0] overflow_evt,
  input  wire logic [NUM_CH-1:0] match_d_raw,
  input  wire logic              match_f_raw,
  input  wire logic              counter_ch4_trough,
  // buffer control towards the counters
  output logic                   pair_e_f_ch0,
  output logic      [NUM_CH-1:0] pair_b_d,
  output logic      [NUM_CH-1:0] match_d_active,
  output logic                   match_f_evt,
  // requests
  output logic      [NUM_CH-1:0] underflow_irq_request,
  output logic      [NUM_CH-1:0] overflow_irq_request,
  output logic      [NUM_CH-1:0] match_d_irq_request,
  output logic                   conv_start_req,
  output logic                   irq
);

  // ==========================================================
  // per-channel registers and flags
  logic [DW-1:0]     mode     [NUM_CH];
  logic [DW-1:0]     ie       [NUM_CH];
  logic [2:0]        flag     [NUM_CH];  // [2] underflow, [1] overflow, [0] match d
  logic [NUM_CH-1:0] d_live;
  logic [NUM_CH-1:0] d_set;
  logic [NUM_CH-1:0] u_set;
  logic [NUM_CH-1:0] next_under_req;
  logic [NUM_CH-1:0] next_over_req;
  logic [NUM_CH-1:0] next_d_req;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [IRQ_W-1:0]  irq_set;
  logic              trough_hit;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic has_d;
      logic has_u;
      assign has_d = (g != 1) && (g != 2);
      assign has_u = !has_d;

      tbi_chan_regs #(
        .CH(g)
      ) u_regs (
        .clk     (clk),
        .sys_rst (sys_rst),
        .mode_we (wr && addr == tbi_reg_addr(MODE_BASE, g)),
        .ie_we   (wr && addr == tbi_reg_addr(IE_BASE, g)),
        .wdata   (wdata),
        .mode    (mode[g]),
        .ie      (ie[g])
      );

      // d stays live on ch0, ch3 and ch4 unless it is a buffer outside complementary pwm; ch1/ch2 have no d
      assign d_live[g] = has_d && (!mode[g][BIT_PAIR_BD] || comp_pwm_mode[g]);
      assign d_set[g]  = match_d_raw[g] && d_live[g];
      assign u_set[g]  = underflow_evt[g] && has_u;

      tbi_sticky #(
        .W(3)
      ) u_flags (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .set      ({u_set[g], overflow_evt[g], d_set[g]}),
        .clr_we   (wr && addr == tbi_reg_addr(STAT_BASE, g)),
        .clr_data ({wdata[BIT_UNDER_EN], wdata[BIT_OVER_EN], wdata[BIT_MATCH_D]}),
        .q        (flag[g])
      );

      // flag and enable, no latching: dropping either drops the request
      assign next_under_req[g] = flag[g][2] && ie[g][BIT_UNDER_EN];
      assign next_over_req[g]  = flag[g][1] && ie[g][BIT_OVER_EN];
      assign next_d_req[g]     = flag[g][0] && ie[g][BIT_MATCH_D];
    end
  endgenerate

  // ==========================================================
  // requests towards the interrupt controller
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      underflow_irq_request <= '0;
      overflow_irq_request  <= '0;
      match_d_irq_request   <= '0;
    end else begin
      underflow_irq_request <= next_under_req;
      overflow_irq_request  <= next_over_req;
      match_d_irq_request   <= next_d_req;
    end
  end

  // ==========================================================
  // buffer pairing and compare enables to the counters
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pair_e_f_ch0   <= 1'b0;
      pair_b_d       <= '0;
      match_d_active <= '0;
      match_f_evt    <= 1'b0;
    end else begin
      pair_e_f_ch0 <= mode[0][BIT_PAIR_EF];
      for (int c = 0; c < NUM_CH; c++) begin
        pair_b_d[c] <= mode[c][BIT_PAIR_BD];
      end
      match_d_active <= d_live;
      // f compare is never gated by the pairing bit
      match_f_evt <= match_f_raw;
    end
  end

  // ==========================================================
  // converter start at the ch4 trough
  assign trough_hit = counter_ch4_trough && comp_pwm_mode[4] && ie[4][BIT_TROUGH_EN];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_start_req <= 1'b0;
    end else begin
      conv_start_req <= trough_hit;
    end
  end

  // ==========================================================
  // summary interrupt: sticky events, write one to clear, masked
  assign irq_set[EV_TROUGH]  = trough_hit;
  assign irq_set[EV_OVER]    = |overflow_evt;
  assign irq_set[EV_UNDER]   = |u_set;
  assign irq_set[EV_MATCH_D] = |d_set;

  tbi_sticky #(
    .W(IRQ_W)
  ) u_irq_stat (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .set      (irq_set),
    .clr_we   (wr && addr == IRQ_STAT),
    .clr_data (wdata[IRQ_W-1:0]),
    .q        (irq_stat)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask <= IRQ_RST;
    end else if (wr && addr == IRQ_MASK) begin
      irq_mask <= wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================
  // read port: data in the cycle after the strobe, unmapped reads zero
  logic [DW-1:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (addr == tbi_reg_addr(MODE_BASE, c)) begin
        next_rdata = mode[c];
      end
      if (addr == tbi_reg_addr(IE_BASE, c)) begin
        next_rdata = ie[c];
      end
      if (addr == tbi_reg_addr(STAT_BASE, c)) begin
        next_rdata = DW'({flag[c], 3'h0});
      end
    end
    if (addr == IRQ_STAT) begin
      next_rdata = DW'(irq_stat);
    end
    if (addr == IRQ_MASK) begin
      next_rdata = DW'(irq_mask);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? next_rdata : '0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_write(logic [7:0] a, int b);
    wr && addr == a && wdata[b];
  endsequence

  a_ef_pairing: assert property (s_write(MODE_BASE, BIT_PAIR_EF) |=> ##1 pair_e_f_ch0)
    else $error("e/f pairing not applied");
  a_bd_pairing: assert property (s_write(8'h0c, BIT_PAIR_BD) |=> ##1 pair_b_d[3])
    else $error("b/d pairing not applied");
  a_d_buffer_quiet: assert property (
    (mode[3][BIT_PAIR_BD] && !comp_pwm_mode[3] && match_d_raw[3]) |=> !flag[3][0] || $past(flag[3][0]))
    else $error("d event taken while buffered");
  a_d_cpwm_match: assert property (
    (comp_pwm_mode[4] && match_d_raw[4]) |=> flag[4][0])
    else $error("d match lost in complementary pwm");
  a_mode_bit5_res: assert property (mode[1][BIT_PAIR_BD] == 1'b0 && mode[2][BIT_PAIR_BD] == 1'b0)
    else $error("mode bit 5 stored on ch1/ch2");
  a_trough_start: assert property (
    (counter_ch4_trough && comp_pwm_mode[4]) |=> conv_start_req == $past(ie[4][BIT_TROUGH_EN]))
    else $error("converter start wrong");
  a_ie6_reserved: assert property (
    s_write(8'h2c, BIT_TROUGH_EN) |=> ##1 (rd |=> rdata[BIT_TROUGH_EN] == 1'b0))
    else $error("ie bit 6 stored on ch3");
  a_under_req: assert property (
    (flag[1][2] && ie[1][BIT_UNDER_EN]) |=> underflow_irq_request[1])
    else $error("underflow request missing");
  a_ie5_reserved: assert property (ie[0][BIT_UNDER_EN] == 1'b0 && ie[4][BIT_UNDER_EN] == 1'b0)
    else $error("ie bit 5 stored on ch0/ch4");
  a_over_req: assert property (
    overflow_irq_request[2] == $past(flag[2][1] && ie[2][BIT_OVER_EN]))
    else $error("overflow request wrong");
  a_d_req: assert property ((flag[0][0] && ie[0][BIT_MATCH_D]) |=> match_d_irq_request[0])
    else $error("d request missing");
  a_ie3_reserved: assert property (ie[2][BIT_MATCH_D] == 1'b0)
    else $error("ie bit 3 stored on ch2");
  a_f_match: assert property (match_f_raw |=> match_f_evt)
    else $error("f compare dropped");
  a_ef_reserved: assert property (mode[3][BIT_PAIR_EF] == 1'b0 && !$rose(mode[1][BIT_PAIR_EF]))
    else $error("e/f pair bit stored off ch0");
  a_req_drops: assert property (!ie[0][BIT_OVER_EN] |=> !overflow_irq_request[0])
    else $error("request held without enable");

  // ==========================================================
  // two-step raise: the flag is sticky, so an enable set one cycle
  // after the event must still produce the request
  sequence s_under_seen;
    underflow_evt[1] ##1 ie[1][BIT_UNDER_EN];
  endsequence

  sequence s_over_seen;
    overflow_evt[2] ##1 ie[2][BIT_OVER_EN];
  endsequence

  a_under_raise: assert property (
    s_under_seen |=> underflow_irq_request[1])
    else $error("underflow request not raised");
  a_under_off: assert property (
    !ie[2][BIT_UNDER_EN] |=> !underflow_irq_request[2])
    else $error("underflow request without enable");
  a_over_raise: assert property (
    s_over_seen |=> overflow_irq_request[2])
    else $error("overflow request not raised");
  a_d_req_off: assert property (
    !ie[4][BIT_MATCH_D] |=> !match_d_irq_request[4])
    else $error("d request without enable");
  a_trough_off: assert property (
    !ie[4][BIT_TROUGH_EN] |=> !conv_start_req)
    else $error("converter start without enable");
  a_d_active_buf: assert property (
    (mode[3][BIT_PAIR_BD] && !comp_pwm_mode[3]) |=> !match_d_active[3])
    else $error("buffered d left live");
  a_d_active_cpwm: assert property (
    comp_pwm_mode[3] |=> match_d_active[3])
    else $error("d compare off in complementary pwm");
  a_ef_unpair: assert property (
    (wr && addr == MODE_BASE && !wdata[BIT_PAIR_EF]) |=> ##1 !pair_e_f_ch0)
    else $error("e/f pairing not released");
  a_bd_unpair: assert property (
    (wr && addr == 8'h0c && !wdata[BIT_PAIR_BD]) |=> ##1 !pair_b_d[3])
    else $error("b/d pairing not released");
  a_f_quiet: assert property (
    !match_f_raw |=> !match_f_evt)
    else $error("f compare without match");
  a_ie3_res_ch1: assert property (
    ie[1][BIT_MATCH_D] == 1'b0)
    else $error("ie bit 3 stored on ch1");
  a_ie6_res_ch0: assert property (
    ie[0][BIT_TROUGH_EN] == 1'b0)
    else $error("ie bit 6 stored on ch0");

endmodule : tbi_top

// File: tb/tbi_top_tb.sv
// testbench for tbi_top: register access, buffer pairing, requests and irq
// assumes: plain register port with read data one cycle late, event inputs are pulses
`timescale 1ns/1ps
module tbi_top_tb
  import tbi_pkg::*;
;
  // ==========================================================
  // signals
  logic              clk           = 1'b0;
  logic              sys_rst       = 1'b1;
  logic [AW-1:0]     addr          = '0;
  logic [DW-1:0]     wdata         = '0;
  logic              wr            = 1'b0;
  logic              rd            = 1'b0;
  logic [NUM_CH-1:0] cpwm          = '0;
  logic [NUM_CH-1:0] un_evt        = '0;
  logic [NUM_CH-1:0] ov_evt        = '0;
  logic [NUM_CH-1:0] md_raw        = '0;
  logic              mf_raw        = 1'b0;
  logic              trough        = 1'b0;
  logic [DW-1:0]     rdata;
  logic              pair_e_f_ch0;
  logic [NUM_CH-1:0] pair_b_d;
  logic [NUM_CH-1:0] md_active;
  logic              match_f_evt;
  logic [NUM_CH-1:0] un_req;
  logic [NUM_CH-1:0] ov_req;
  logic [NUM_CH-1:0] md_req;
  logic              conv_start_req;
  logic              irq;
  logic              chk           = 1'b0;
  logic              rd_seen       = 1'b0;
  logic [7:0]        n_conv        = '0;
  logic [7:0]        n_f           = '0;
  int                n_mismatch    = 0;
  int                cmp_count     = 0;
  integer            seed          = 61;
  logic [7:0]        q_rd[$];
  logic [21:0]       q_out[$];
  wire  [21:0]       obs = {irq, md_req, ov_req, un_req, pair_b_d, pair_e_f_ch0};

  always #5 clk = ~clk;

  tbi_top i_tbi_top (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .comp_pwm_mode(cpwm), .underflow_evt(un_evt), .overflow_evt(ov_evt),
    .match_d_raw(md_raw), .match_f_raw(mf_raw), .counter_ch4_trough(trough),
    .pair_e_f_ch0(pair_e_f_ch0), .pair_b_d(pair_b_d), .match_d_active(md_active),
    .match_f_evt(match_f_evt), .underflow_irq_request(un_req),
    .overflow_irq_request(ov_req), .match_d_irq_request(md_req),
    .conv_start_req(conv_start_req), .irq(irq)
  );

  // ==========================================================
  // compare and report
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp8

  task automatic cmp_out(input logic [21:0] e, input logic [21:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD outputs expected %h seen %h", e, g);
    end
  endtask : cmp_out

  task automatic close_out;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // monitor: takes the oldest note whenever a result appears
  always @(posedge clk) begin
    if (rd_seen) begin
      cmp8("rdata", q_rd.pop_front(), rdata);
    end
    if (chk) begin
      cmp_out(q_out.pop_front(), obs);
    end
    if (conv_start_req === 1'b1) n_conv <= n_conv + 8'h01;
    if (match_f_evt === 1'b1) n_f <= n_f + 8'h01;
    rd_seen <= rd;
  end

  // ==========================================================
  // drivers
  function automatic logic [7:0] ra(input logic [7:0] base, input int ch);
    return base + 8'(4 * ch);
  endfunction : ra

  function automatic logic [21:0] ex(input logic i, input logic [4:0] md, input logic [4:0] ov,
                                     input logic [4:0] un, input logic [4:0] bd, input logic ef);
    return {i, md, ov, un, bd, ef};
  endfunction : ex

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    q_rd.push_back(e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
  endtask : rd_reg

  // one-cycle pulse on the counter-side event inputs
  task automatic ev(input logic [4:0] ov, input logic [4:0] un, input logic [4:0] md,
                    input logic tr, input logic f);
    @(posedge clk);
    ov_evt <= ov;
    un_evt <= un;
    md_raw <= md;
    trough <= tr;
    mf_raw <= f;
    @(posedge clk);
    ov_evt <= '0;
    un_evt <= '0;
    md_raw <= '0;
    trough <= 1'b0;
    mf_raw <= 1'b0;
  endtask : ev

  // two settle cycles cover the flag stage and the registered request
  task automatic chk_out(input logic [21:0] e);
    repeat (2) @(posedge clk);
    q_out.push_back(e);
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask : chk_out

  task automatic clr_flags;
    for (int c = 0; c < NUM_CH; c++) wr_reg(ra(STAT_BASE, c), 8'h38);
    wr_reg(IRQ_STAT, 8'h0f);
  endtask : clr_flags

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] mm[5];
    logic [7:0] im[5];
    logic [7:0] d;
    mm = '{8'h7f, 8'h1f, 8'h1f, 8'h3f, 8'h3f};
    im = '{8'h9f, 8'hb7, 8'hb7, 8'h9f, 8'hdf};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      rd_reg(ra(MODE_BASE, c), MODE_RST);
      rd_reg(ra(IE_BASE, c), IE_RST);
      d = 8'($random(seed));
      wr_reg(ra(MODE_BASE, c), d);
      rd_reg(ra(MODE_BASE, c), d & mm[c]);
      d = 8'($random(seed));
      wr_reg(ra(IE_BASE, c), d);
      rd_reg(ra(IE_BASE, c), d & im[c]);
    end
    rd_reg(8'h14, 8'h00);
    // pairing: ch0 e/f, ch3 b/d; ch1 refuses both pair bits; counters idle meanwhile
    wr_reg(ra(MODE_BASE, 0), 8'h40);
    wr_reg(ra(MODE_BASE, 1), 8'h60);
    wr_reg(ra(MODE_BASE, 2), 8'h00);
    wr_reg(ra(MODE_BASE, 3), 8'h20);
    wr_reg(ra(MODE_BASE, 4), 8'h00);
    for (int c = 0; c < NUM_CH; c++) wr_reg(ra(IE_BASE, c), 8'hff);
    wr_reg(IRQ_MASK, 8'h0f);
    clr_flags();
    chk_out(ex(1'b0, 5'h00, 5'h00, 5'h00, 5'b01000, 1'b1));
    @(negedge clk);
    cmp8("d_active", 8'h11, 8'(md_active));
    // overflow, underflow and d events on all channels, no trough or f, no complementary pwm
    ev(5'h1f, 5'h1f, 5'h1f, 1'b0, 1'b0);
    chk_out(ex(1'b1, 5'b10001, 5'h1f, 5'b00110, 5'b01000, 1'b1));
    clr_flags();
    chk_out(ex(1'b0, 5'h00, 5'h00, 5'h00, 5'b01000, 1'b1));
    // complementary pwm on ch3/ch4: d enable kept clear there, buffered d still matches
    wr_reg(ra(IE_BASE, 3), 8'h10);
    wr_reg(ra(IE_BASE, 4), 8'h50);
    cpwm <= 5'b11000;
    ev(5'h00, 5'h00, 5'h1f, 1'b0, 1'b0);
    chk_out(ex(1'b1, 5'b00001, 5'h00, 5'h00, 5'b01000, 1'b1));
    @(negedge clk);
    cmp8("d_active", 8'h19, 8'(md_active));
    rd_reg(ra(STAT_BASE, 3), 8'h08);
    rd_reg(ra(STAT_BASE, 4), 8'h08);
    wr_reg(ra(IE_BASE, 0), 8'h10);
    chk_out(ex(1'b1, 5'h00, 5'h00, 5'h00, 5'b01000, 1'b1));
    // trough starts: two enabled, one after the enable is dropped
    ev(5'h00, 5'h00, 5'h00, 1'b1, 1'b1);
    ev(5'h00, 5'h00, 5'h00, 1'b1, 1'b1);
    wr_reg(ra(IE_BASE, 4), 8'h00);
    ev(5'h00, 5'h00, 5'h00, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    cmp8("conv_start", 8'h02, n_conv);
    cmp8("match_f", 8'h02, n_f);
    // masking of the summary interrupt
    cpwm <= 5'h00;
    clr_flags();
    wr_reg(IRQ_MASK, 8'h00);
    ev(5'b00100, 5'h00, 5'h00, 1'b0, 1'b0);
    chk_out(ex(1'b0, 5'h00, 5'b00100, 5'h00, 5'b01000, 1'b1));
    wr_reg(IRQ_MASK, 8'h02);
    chk_out(ex(1'b1, 5'h00, 5'b00100, 5'h00, 5'b01000, 1'b1));
    rd_reg(IRQ_STAT, 8'h02);
    repeat (3) @(posedge clk);
    close_out();
  end

  // ==========================================================
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #50us;
    n_mismatch++;
    close_out();
  end
endmodule : tbi_top_tb
